//--- rtl/eesc_pkg.sv
// Package with register map and carrier types of the event enable bank.
package eesc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHAN_N = 64;

    localparam logic [ADDR_W-1:0] OFF_MASK_LOW  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASK_HIGH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CLR_LOW   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CLR_HIGH  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_SET_LOW   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SET_HIGH  = 8'h14;

    localparam logic [CHAN_N-1:0] RST_MASK = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    // Bit positions of the two halves inside the 64-bit mask.
    localparam int unsigned LOW_LSB  = 0;
    localparam int unsigned HIGH_LSB = 32;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eesc_req_t;

    typedef struct packed {
        logic [CHAN_N-1:0] latched;
        logic [CHAN_N-1:0] chained;
        logic [CHAN_N-1:0] manual;
    } eesc_trig_t;

endpackage : eesc_pkg

//--- rtl/eesc_event_enable.sv
// Event enable mask with write-only set and clear ports.
//
// Notes on behaviour
// - Mask ignores direct writes; only ports change it.
// - Low clear port clears mask bits 0-31.
// - High clear port clears mask bits 32-63.
// - Low set port sets mask bits 0-31.
// - High set port sets mask bits 32-63.
// - Zero data bits leave mask bits unchanged.
// - Four ports write-only, zero after reset.
// - Enabled bit lets latched trigger be evaluated.
// - Enabling pending latched trigger processes it.
// - Chained and manual triggers bypass the mask.
// - Mask readable, zero after reset.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module eesc_event_enable
    import eesc_pkg::*;
(
    // Clock and reset.
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Register port.
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rdata_out,
    // Trigger sources from the controller, same clock.
    input  wire logic [CHAN_N-1:0] latched_trig_flags_in,
    input  wire logic [CHAN_N-1:0] chained_flags_in,
    input  wire logic [CHAN_N-1:0] manual_trigger_flags_in,
    // Mask and triggers that the controller may evaluate.
    output logic      [CHAN_N-1:0] event_enable_mask_out,
    output logic      [CHAN_N-1:0] eval_trig_out
);

    eesc_req_t         req;
    eesc_trig_t        trig;
    logic [CHAN_N-1:0] mask;
    logic [CHAN_N-1:0] next_mask;
    logic [CHAN_N-1:0] set_bits;
    logic [CHAN_N-1:0] clr_bits;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic [CHAN_N-1:0] eval;
    logic [CHAN_N-1:0] next_eval;

    assign req  = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
    assign trig = '{latched: latched_trig_flags_in,
                    chained: chained_flags_in,
                    manual:  manual_trigger_flags_in};

    // Decodes a write strobe for one offset.
    function automatic logic hit(input eesc_req_t r,
                                 input logic [ADDR_W-1:0] off);
        hit = r.wr && (r.addr == off);
    endfunction : hit

    // Ports hold no storage, so only the strobed data forms the masks.
    always_comb begin
        set_bits = RST_MASK;
        clr_bits = RST_MASK;
        if (hit(req, OFF_SET_LOW)) begin
            set_bits[LOW_LSB +: DATA_W] = req.wdata;
        end
        if (hit(req, OFF_SET_HIGH)) begin
            set_bits[HIGH_LSB +: DATA_W] = req.wdata;
        end
        if (hit(req, OFF_CLR_LOW)) begin
            clr_bits[LOW_LSB +: DATA_W] = req.wdata;
        end
        if (hit(req, OFF_CLR_HIGH)) begin
            clr_bits[HIGH_LSB +: DATA_W] = req.wdata;
        end
    end

    // Writes to the mask offsets fall through with no effect.
    always_comb begin
        next_mask = (mask & ~clr_bits) | set_bits;
    end

    // Ports, unmapped offsets and idle cycles all read as zero.
    always_comb begin
        next_rdata = RST_WORD;
        if (req.rd) begin
            case (req.addr)
                OFF_MASK_LOW:  next_rdata = mask[LOW_LSB +: DATA_W];
                OFF_MASK_HIGH: next_rdata = mask[HIGH_LSB +: DATA_W];
                default:       next_rdata = RST_WORD;
            endcase
        end
    end

    // A pending latched trigger appears as soon as its bit is enabled,
    // just as a new arrival would.
    always_comb begin
        next_eval = (trig.latched & next_mask)
                  | trig.chained | trig.manual;
    end

    // Mask state; reset leaves every channel disabled.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= RST_MASK;
        end else begin
            mask <= next_mask;
        end
    end

    // Read data; cleared in every cycle that carries no read.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata <= RST_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Gated triggers towards the controller.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eval <= RST_MASK;
        end else begin
            eval <= next_eval;
        end
    end

    assign rdata_out             = rdata;
    assign event_enable_mask_out = mask;
    assign eval_trig_out         = eval;

    // Port writes: ones act on their own half, zeros and the other half stay.
    a_clr_low_clears: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_LOW)
        |=> (mask[LOW_LSB +: DATA_W] & $past(req.wdata)) == 32'h0000_0000)
        else $error("low clear left a bit set");

    a_clr_high_clears: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_HIGH)
        |=> (mask[HIGH_LSB +: DATA_W] & $past(req.wdata)) == 32'h0000_0000)
        else $error("high clear left a bit set");

    a_set_low_sets: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_LOW)
        |=> (mask[LOW_LSB +: DATA_W] & $past(req.wdata))
            == $past(req.wdata))
        else $error("low set missed a bit");

    a_set_high_sets: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_HIGH)
        |=> (mask[HIGH_LSB +: DATA_W] & $past(req.wdata))
            == $past(req.wdata))
        else $error("high set missed a bit");

    a_zero_untouched: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_LOW)
        |=> (mask[LOW_LSB +: DATA_W] & ~$past(req.wdata))
            == ($past(mask[LOW_LSB +: DATA_W]) & ~$past(req.wdata)))
        else $error("zero bit changed the mask");

    a_zero_clr_low: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_LOW)
        |=> (mask[LOW_LSB +: DATA_W] & ~$past(req.wdata))
            == ($past(mask[LOW_LSB +: DATA_W]) & ~$past(req.wdata)))
        else $error("zero bit of low clear changed the mask");

    a_zero_set_high: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_HIGH)
        |=> (mask[HIGH_LSB +: DATA_W] & ~$past(req.wdata))
            == ($past(mask[HIGH_LSB +: DATA_W]) & ~$past(req.wdata)))
        else $error("zero bit of high set changed the mask");

    a_zero_clr_high: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_HIGH)
        |=> (mask[HIGH_LSB +: DATA_W] & ~$past(req.wdata))
            == ($past(mask[HIGH_LSB +: DATA_W]) & ~$past(req.wdata)))
        else $error("zero bit of high clear changed the mask");

    a_low_keeps_high: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_LOW) || hit(req, OFF_CLR_LOW)
        |=> $stable(mask[HIGH_LSB +: DATA_W]))
        else $error("low port changed the high half");

    a_high_keeps_low: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_HIGH) || hit(req, OFF_CLR_HIGH)
        |=> $stable(mask[LOW_LSB +: DATA_W]))
        else $error("high port changed the low half");

    a_mask_stable: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !(hit(req, OFF_SET_LOW) || hit(req, OFF_SET_HIGH) ||
          hit(req, OFF_CLR_LOW) || hit(req, OFF_CLR_HIGH))
        |=> $stable(mask))
        else $error("mask changed without a port write");

    a_mask_write_ignored: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_MASK_LOW) || hit(req, OFF_MASK_HIGH)
        |=> $stable(mask))
        else $error("direct mask write took effect");

    // Reads: only the mask words return data, and only for one cycle.
    a_port_read_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        req.rd && (req.addr == OFF_SET_LOW || req.addr == OFF_SET_HIGH ||
                   req.addr == OFF_CLR_LOW || req.addr == OFF_CLR_HIGH)
        |=> rdata_out == 32'h0000_0000 && $stable(mask))
        else $error("port read returned data");

    a_read_keeps_mask: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        req.rd
        |=> $stable(mask))
        else $error("read changed the mask");

    a_idle_read_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !req.rd
        |=> rdata_out == 32'h0000_0000)
        else $error("read data outside its cycle");

    a_other_read_zero: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        req.rd && req.addr != OFF_MASK_LOW
               && req.addr != OFF_MASK_HIGH
        |=> rdata_out == 32'h0000_0000)
        else $error("non mask read returned data");

    a_mask_low_readback: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        req.rd && req.addr == OFF_MASK_LOW
        |=> rdata_out == $past(mask[LOW_LSB +: DATA_W]))
        else $error("mask low read wrong");

    a_mask_readback: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        req.rd && req.addr == OFF_MASK_HIGH
        |=> rdata_out == $past(mask[HIGH_LSB +: DATA_W]))
        else $error("mask high read wrong");

    // Reset is asynchronous, so this one is sampled while it is held.
    a_reset_clears: assert property (
        @(posedge ref_clk_in)
        rst_in
        |=> mask == RST_MASK && rdata_out == RST_WORD
            && eval_trig_out == RST_MASK)
        else $error("state not cleared by reset");

    // Triggers: the mask gates only latched ones, on the updated mask.
    a_eval_gating: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        ##1 eval_trig_out == (($past(trig.latched) & mask)
            | $past(trig.chained) | $past(trig.manual)))
        else $error("trigger gating wrong");

    a_masked_held_off: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        ##1 (eval_trig_out & ~mask & ~$past(trig.chained)
             & ~$past(trig.manual)) == RST_MASK)
        else $error("disabled channel passed a trigger");

    a_clr_disables: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_LOW)
        |=> (eval_trig_out[LOW_LSB +: DATA_W] & $past(req.wdata)
             & ~$past(trig.chained[LOW_LSB +: DATA_W])
             & ~$past(trig.manual[LOW_LSB +: DATA_W])) == 32'h0000_0000)
        else $error("cleared low channel passed a trigger");

    a_clr_high_disables: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_CLR_HIGH)
        |=> (eval_trig_out[HIGH_LSB +: DATA_W] & $past(req.wdata)
             & ~$past(trig.chained[HIGH_LSB +: DATA_W])
             & ~$past(trig.manual[HIGH_LSB +: DATA_W])) == 32'h0000_0000)
        else $error("cleared high channel passed a trigger");

    a_pending_enable: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_LOW)
        |=> (eval_trig_out[LOW_LSB +: DATA_W]
             & $past(trig.latched[LOW_LSB +: DATA_W]) & $past(req.wdata))
            == ($past(trig.latched[LOW_LSB +: DATA_W]) & $past(req.wdata)))
        else $error("pending low trigger not raised");

    a_pending_high: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        hit(req, OFF_SET_HIGH)
        |=> (eval_trig_out[HIGH_LSB +: DATA_W]
             & $past(trig.latched[HIGH_LSB +: DATA_W]) & $past(req.wdata))
            == ($past(trig.latched[HIGH_LSB +: DATA_W]) & $past(req.wdata)))
        else $error("pending high trigger not raised");

    a_trig_bypass: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        ##1 (eval_trig_out & ($past(trig.chained) | $past(trig.manual)))
            == ($past(trig.chained) | $past(trig.manual)))
        else $error("chained or manual trigger was masked");

endmodule : eesc_event_enable

//--- bench/eesc_event_enable_test.sv
// Self-checking testbench of the event enable bank.
`timescale 1ns/100ps
module eesc_event_enable_test;
    import eesc_pkg::*;
    logic              clk = 1'b0;
    logic              rst_in = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [CHAN_N-1:0] lat = '0, chn = '0, man = '0, mask, evt;
    logic [CHAN_N-1:0] exp_mask = RST_MASK;
    logic [ADDR_W-1:0] offs [6] = '{OFF_MASK_LOW, OFF_MASK_HIGH, OFF_CLR_LOW,
                                    OFF_CLR_HIGH, OFF_SET_LOW, OFF_SET_HIGH};
    int                num_errors = 0;
    int                total_checks = 0;

    always #20 clk = ~clk;

    eesc_event_enable u_dut (.ref_clk_in(clk), .rst_in(rst_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .latched_trig_flags_in(lat),
        .chained_flags_in(chn), .manual_trigger_flags_in(man),
        .event_enable_mask_out(mask), .eval_trig_out(evt));

    function automatic logic [CHAN_N-1:0] next_mask(
            logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        logic [CHAN_N-1:0] m;
        m = exp_mask;
        case (a)
            OFF_CLR_LOW:  m[31:0]  = m[31:0] & ~d;
            OFF_CLR_HIGH: m[63:32] = m[63:32] & ~d;
            OFF_SET_LOW:  m[31:0]  = m[31:0] | d;
            OFF_SET_HIGH: m[63:32] = m[63:32] | d;
            default:      m = exp_mask;
        endcase
        return m;
    endfunction : next_mask

    // Only the mask words read back; the ports read as zero.
    function automatic logic [DATA_W-1:0] rd_exp(logic [ADDR_W-1:0] a);
        if (a == OFF_MASK_LOW) return exp_mask[31:0];
        if (a == OFF_MASK_HIGH) return exp_mask[63:32];
        return RST_WORD;
    endfunction : rd_exp

    task automatic chk(string what, logic [CHAN_N-1:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Chained and manual triggers are kept sparse so masking stays visible.
    function automatic logic [CHAN_N-1:0] sparse();
        return {$urandom, $urandom} & {$urandom, $urandom}
               & {$urandom, $urandom};
    endfunction : sparse

    task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        lat <= {$urandom, $urandom};
        chn <= sparse();
        man <= sparse();
        @(posedge clk);
        wr <= 1'b0;
        exp_mask = next_mask(a, d);
        #1;
        chk("mask", mask, exp_mask);
        chk("eval", evt, (lat & exp_mask) | chn | man);
        chk("rdata idle", {32'h0, rdata}, 64'h0);
    endtask : wr_reg

    task automatic rd_reg(logic [ADDR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {32'h0, rdata}, {32'h0, rd_exp(a)});
    endtask : rd_reg

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h4d5c));
        repeat (4) @(posedge clk);
        rst_in <= 1'b0;
        #1;
        chk("reset mask", mask, RST_MASK);
        for (int i = 0; i < 6; i++) rd_reg(offs[i]);
        $display("test reset done");
        // All ones then all zeros to every location, plus all ones to an unmapped one.
        for (int i = 0; i < 6; i++) begin
            wr_reg(offs[i], 32'hffff_ffff);
            wr_reg(offs[i], 32'h0000_0000);
            rd_reg(offs[i]);
        end
        wr_reg(8'hfc, 32'hffff_ffff);
        rd_reg(8'hfc);
        $display("test corner done");
        for (int n = 0; n < 300; n++) begin
            wr_reg(($urandom_range(6) == 6) ? 8'hfc : offs[$urandom_range(5)],
                   $urandom);
            rd_reg(offs[$urandom_range(5)]);
        end
        $display("test random done");
        // Reset in mid-run, with the trigger inputs quiet around it.
        @(posedge clk);
        lat <= '0;
        chn <= '0;
        man <= '0;
        rst_in <= 1'b1;
        #1;
        exp_mask = RST_MASK;
        chk("mid reset mask", mask, RST_MASK);
        repeat (2) @(posedge clk);
        rst_in <= 1'b0;
        #1;
        chk("mid reset eval", evt, RST_MASK);
        for (int i = 0; i < 6; i++) rd_reg(offs[i]);
        wr_reg(OFF_SET_HIGH, $urandom);
        $display("test mid reset done");
        wrap_up();
    end
endmodule : eesc_event_enable_test
